// ===== hw/sdc_top.v
// Configuration and dynamic memory control registers with SDRAM clock and command control.
`include "sdc_regs.vh"
module sdc_top #(
  parameter NUM_DEVS = 4,
  parameter ADDR_W = 12
) (
  // Clock, resets and enable.
  input wire ref_clk,
  input wire sys_rst,
  input wire bus_rst,
  input wire clk_en,
  // Register port.
  input wire reg_sel,
  input wire reg_write,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output wire reg_ready,
  // Pins from outside the clock domain.
  input wire big_endian_strap,
  input wire memory_core_clock,
  // Idle flags of the SDRAM devices from the access logic.
  input wire [NUM_DEVS-1:0] sdram_idle,
  // SDRAM side.
  output wire memory_clock_out,
  output wire [NUM_DEVS-1:0] sdram_cke,
  output wire [2:0] sdram_cmd,
  output wire sdram_cmd_active,
  // Mode and flash outputs.
  output wire big_endian_mode,
  output wire clock_ratio_half,
  output wire flash_high_voltage_out,
  output wire flash_reset_powerdown_n,
  output wire deep_power_down_req,
  output wire self_refresh_request,
  output wire self_refresh_ack,
  output wire init_hold_off
);

  // ****************************************************************
  // Synchronisers and memory clock edge detect.
  // ****************************************************************
  wire strap_sync;
  wire core_sync;
  reg core_prev_ff;
  wire mem_rise;

  sdc_sync2 u_strap_sync (
    .clk(ref_clk),
    .rst(sys_rst),
    .en(clk_en),
    .async_in(big_endian_strap),
    .sync_out(strap_sync)
  );

  sdc_sync2 u_core_sync (
    .clk(ref_clk),
    .rst(sys_rst),
    .en(clk_en),
    .async_in(memory_core_clock),
    .sync_out(core_sync)
  );

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      core_prev_ff <= 1'b0;
    end else if (clk_en) begin
      core_prev_ff <= core_sync;
    end
  end

  assign mem_rise = core_sync & ~core_prev_ff;

  // ****************************************************************
  // Register port decode and wait states.
  // ****************************************************************
  wire cfg_hit;
  wire dyn_hit;
  wire sta_hit;
  reg wait_ff;
  wire acc_done;
  wire wr_cfg;
  wire wr_dyn;

  assign cfg_hit = reg_sel & (reg_addr == `SDC_CONFIG_OFS);
  assign dyn_hit = reg_sel & (reg_addr == `SDC_DYNCTL_OFS);
  assign sta_hit = reg_sel & (reg_addr == `SDC_STATUS_OFS);

  // The configuration register stalls its access for one cycle.
  always @(posedge ref_clk) begin
    if (sys_rst || bus_rst) begin
      wait_ff <= 1'b0;
    end else if (clk_en) begin
      wait_ff <= cfg_hit & ~wait_ff;
    end
  end

  assign reg_ready = ~(cfg_hit & ~wait_ff);
  assign acc_done = reg_sel & reg_ready & clk_en;
  assign wr_cfg = acc_done & reg_write & cfg_hit;
  assign wr_dyn = acc_done & reg_write & dyn_hit;

  // ****************************************************************
  // Configuration register.
  // ****************************************************************
  reg ratio_ff;
  reg endian_ff;
  reg strap_track_ff;

  // Only the power-on reset touches these; the bus reset leaves them alone.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ratio_ff <= `SDC_RST_RATIO;
      endian_ff <= 1'b0;
      strap_track_ff <= 1'b1;
    end else if (clk_en) begin
      if (wr_cfg) begin
        ratio_ff <= reg_wdata[`SDC_CFG_RATIO_BIT];
        endian_ff <= reg_wdata[`SDC_CFG_ENDIAN_BIT];
        strap_track_ff <= 1'b0;
      end else if (strap_track_ff) begin
        endian_ff <= strap_sync;
      end
    end
  end

  assign big_endian_mode = endian_ff;
  assign clock_ratio_half = ratio_ff;

  // ****************************************************************
  // Dynamic memory control register.
  // ****************************************************************
  reg hv_ff;
  reg rp_ff;
  reg dp_ff;
  reg [1:0] init_ff;
  reg mmc_ff;
  reg sr_ff;
  reg cs_ff;
  reg ce_ff;
  wire [1:0] wr_init;

  assign wr_init = reg_wdata[`SDC_DYN_INIT_HI:`SDC_DYN_INIT_LO];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hv_ff <= `SDC_RST_HV;
      rp_ff <= `SDC_RST_RP;
      dp_ff <= `SDC_RST_DP;
      init_ff <= `SDC_RST_INIT;
      mmc_ff <= `SDC_RST_MMC;
      sr_ff <= `SDC_RST_SR;
      cs_ff <= `SDC_RST_CS;
      ce_ff <= `SDC_RST_CE;
    end else if (wr_dyn) begin
      hv_ff <= reg_wdata[`SDC_DYN_HV_BIT];
      rp_ff <= reg_wdata[`SDC_DYN_RP_BIT];
      dp_ff <= reg_wdata[`SDC_DYN_DP_BIT];
      init_ff <= wr_init;
      mmc_ff <= reg_wdata[`SDC_DYN_MMC_BIT];
      sr_ff <= reg_wdata[`SDC_DYN_SR_BIT];
      cs_ff <= reg_wdata[`SDC_DYN_CS_BIT];
      ce_ff <= reg_wdata[`SDC_DYN_CE_BIT];
    end
  end

  assign flash_high_voltage_out = hv_ff;
  assign flash_reset_powerdown_n = rp_ff;
  assign deep_power_down_req = dp_ff;
  assign self_refresh_request = sr_ff;
  assign init_hold_off = (init_ff != `SDC_INIT_NORMAL);

  // ****************************************************************
  // Command requests: initialization commands and self-refresh entry.
  // ****************************************************************
  wire all_idle;
  wire init_go;
  wire sref_go;
  reg [2:0] init_cmd;
  wire cmd_busy;
  wire cmd_issued;
  reg sref_wait_ff;
  reg sa_ff;

  assign all_idle = &sdram_idle;

  always @* begin
    case (wr_init)
      `SDC_INIT_MODE: init_cmd = `SDC_CMD_MODE;
      `SDC_INIT_PRECHARGE_ALL_CMD: init_cmd = `SDC_CMD_PRECHARGE_ALL_CMD;
      `SDC_INIT_NOP: init_cmd = `SDC_CMD_NOP;
      default: init_cmd = `SDC_CMD_NOP;
    endcase
  end

  assign init_go = wr_dyn & (wr_init != `SDC_INIT_NORMAL);
  // Self-refresh entry waits for idle devices and gives way to dynamic control register writes.
  assign sref_go = sr_ff & ~sa_ff & ~sref_wait_ff & all_idle & ~init_hold_off
    & ~wr_dyn & ~cmd_busy;

  sdc_cmd_issue u_cmd (
    .clk(ref_clk),
    .rst(sys_rst),
    .en(clk_en),
    .mem_rise(mem_rise),
    .req_valid(init_go | sref_go),
    .req_cmd(init_go ? init_cmd : `SDC_CMD_SREF),
    .busy(cmd_busy),
    .issued(cmd_issued),
    .cmd_out(sdram_cmd),
    .cmd_active(sdram_cmd_active)
  );

  // The acknowledge follows the actual command, so it lags the request bit.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sref_wait_ff <= 1'b0;
      sa_ff <= `SDC_RST_SA;
    end else if (clk_en) begin
      if (sref_go && !init_go) begin
        sref_wait_ff <= 1'b1;
      end else if (sref_wait_ff && cmd_issued) begin
        sref_wait_ff <= 1'b0;
        sa_ff <= 1'b1;
      end else if (!sr_ff && sa_ff && !sref_wait_ff && mem_rise) begin
        sa_ff <= 1'b0;
      end
    end
  end

  assign self_refresh_ack = sa_ff;

  // ****************************************************************
  // Clock enables and memory output clock.
  // ****************************************************************
  reg [NUM_DEVS-1:0] cke_ff;
  reg half_ff;
  reg clk_out_ff;
  wire clk_run;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cke_ff <= {NUM_DEVS{1'b0}};
    end else if (clk_en) begin
      if (sa_ff || dp_ff) begin
        cke_ff <= {NUM_DEVS{1'b0}};
      end else if (ce_ff) begin
        cke_ff <= {NUM_DEVS{1'b1}};
      end else begin
        cke_ff <= ~sdram_idle;
      end
    end
  end

  assign sdram_cke = cke_ff;

  // Clock runs when enabled and either free-running or needed by traffic or a command.
  assign clk_run = ~mmc_ff & (cs_ff | (~sa_ff & (~all_idle | cmd_busy | sdram_cmd_active)));

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      half_ff <= 1'b0;
      clk_out_ff <= 1'b0;
    end else if (clk_en) begin
      if (mem_rise) begin
        half_ff <= ~half_ff;
      end
      if (!clk_run) begin
        clk_out_ff <= 1'b0;
      end else if (ratio_ff) begin
        clk_out_ff <= half_ff;
      end else begin
        clk_out_ff <= core_sync;
      end
    end
  end

  assign memory_clock_out = clk_out_ff;

  // ****************************************************************
  // Read data.
  // ****************************************************************
  always @* begin
    reg_rdata = 32'h0;
    if (cfg_hit) begin
      reg_rdata[`SDC_CFG_RATIO_BIT] = ratio_ff;
      reg_rdata[`SDC_CFG_ENDIAN_BIT] = endian_ff;
    end else if (dyn_hit) begin
      reg_rdata[`SDC_DYN_HV_BIT] = hv_ff;
      reg_rdata[`SDC_DYN_RP_BIT] = rp_ff;
      reg_rdata[`SDC_DYN_DP_BIT] = dp_ff;
      reg_rdata[`SDC_DYN_INIT_HI:`SDC_DYN_INIT_LO] = init_ff;
      reg_rdata[`SDC_DYN_MMC_BIT] = mmc_ff;
      reg_rdata[`SDC_DYN_SR_BIT] = sr_ff;
      reg_rdata[`SDC_DYN_CS_BIT] = cs_ff;
      reg_rdata[`SDC_DYN_CE_BIT] = ce_ff;
    end else if (sta_hit) begin
      reg_rdata[`SDC_STA_SA_BIT] = sa_ff;
      reg_rdata[`SDC_STA_BUSY_BIT] = cmd_busy | sref_wait_ff;
    end
  end

endmodule // sdc_top

// ===== shared/sdc_regs.vh
// Register offsets, field positions, reset values and command codes of the SDRAM control block.
// Summary of operation
// - Config bit 8 picks bus to memory clock ratio, 0 is 1:1, 1 is 1:2.
// - Config bit 0 picks byte order, 0 little-endian, 1 big-endian.
// - Power-on loads endian from strap; software may override; bus reset leaves it.
// - After a software write the endian field reads the last written value.
// - Dynamic bit 15 drives flash high-voltage output; 0 after power-on.
// - Dynamic bit 14 drives active-low flash reset output; low after power-on.
// - Dynamic bit 13 requests deep power-down; 0 means normal operation.
// - Init field picks command: 00 normal, 01 mode set, 10 precharge all, 11 NOP.
// - Dynamic bit 5 disables memory output clock; 0 after power-on.
// - Dynamic bit 2 requests self-refresh, 0 returns to normal; 1 after power-on.
// - Dynamic bit 1 low stops memory clock when idle or self-refreshing; high runs.
// - Dynamic bit 0 low drops idle clock enables; high holds all enables high except in self-refresh or deep power-down.
// - Dynamic register changes anytime and completes with zero wait states.
// - Unused bits read undefined, here zero; software writes zeros to them.
// - Read-only status bit shows mode: 0 normal, 1 self-refresh; 1 after power-on.
// - Configuration register accesses complete with one wait state.
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define SDC_CONFIG_OFS 12'h000
`define SDC_DYNCTL_OFS 12'h004
`define SDC_STATUS_OFS 12'h008

// ****************************************************************
// Field positions.
// ****************************************************************
`define SDC_CFG_RATIO_BIT 8
`define SDC_CFG_ENDIAN_BIT 0
`define SDC_DYN_HV_BIT 15
`define SDC_DYN_RP_BIT 14
`define SDC_DYN_DP_BIT 13
`define SDC_DYN_INIT_HI 8
`define SDC_DYN_INIT_LO 7
`define SDC_DYN_MMC_BIT 5
`define SDC_DYN_SR_BIT 2
`define SDC_DYN_CS_BIT 1
`define SDC_DYN_CE_BIT 0
`define SDC_STA_SA_BIT 2
`define SDC_STA_BUSY_BIT 0

// ****************************************************************
// Power-on reset values.
// ****************************************************************
`define SDC_RST_RATIO 1'h0
`define SDC_RST_HV 1'h0
`define SDC_RST_RP 1'h0
`define SDC_RST_DP 1'h0
`define SDC_RST_INIT 2'h0
`define SDC_RST_MMC 1'h0
`define SDC_RST_SR 1'h1
`define SDC_RST_CS 1'h1
`define SDC_RST_CE 1'h0
`define SDC_RST_SA 1'h1

// ****************************************************************
// Init field codes and SDRAM commands as {ras_n, cas_n, we_n}.
// ****************************************************************
`define SDC_INIT_NORMAL 2'h0
`define SDC_INIT_MODE 2'h1
`define SDC_INIT_PRECHARGE_ALL_CMD 2'h2
`define SDC_INIT_NOP 2'h3
`define SDC_CMD_NOP 3'h7
`define SDC_CMD_MODE 3'h0
`define SDC_CMD_PRECHARGE_ALL_CMD 3'h2
`define SDC_CMD_SREF 3'h1

`endif

// ===== hw/sdc_sync2.v
// Two flip-flop synchroniser for a level from outside the clock domain.
module sdc_sync2 (
  // Clock, reset and enable.
  input wire clk,
  input wire rst,
  input wire en,
  // Asynchronous level in, synchronised level out.
  input wire async_in,
  output wire sync_out
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // sdc_sync2

// ===== hw/sdc_cmd_issue.v
// Holds one pending SDRAM command and launches it on the next memory clock edge.
`include "sdc_regs.vh"
module sdc_cmd_issue (
  // Clock, reset and enable.
  input wire clk,
  input wire rst,
  input wire en,
  // Rising edge of the memory clock, one cycle pulse.
  input wire mem_rise,
  // Command request.
  input wire req_valid,
  input wire [2:0] req_cmd,
  output wire busy,
  output wire issued,
  // SDRAM command outputs.
  output wire [2:0] cmd_out,
  output wire cmd_active
);
  reg pend_ff;
  reg [2:0] pend_cmd_ff;
  reg [2:0] cmd_ff;
  reg act_ff;

  // A command waits for the memory edge so it spans one full memory clock period.
  always @(posedge clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      pend_cmd_ff <= `SDC_CMD_NOP;
      cmd_ff <= `SDC_CMD_NOP;
      act_ff <= 1'b0;
    end else if (en) begin
      if (mem_rise) begin
        cmd_ff <= pend_ff ? pend_cmd_ff : `SDC_CMD_NOP;
        act_ff <= pend_ff;
        // A request that meets a memory edge with nothing pending is kept for the next edge.
        pend_ff <= req_valid & ~pend_ff;
        if (req_valid && !pend_ff) begin
          pend_cmd_ff <= req_cmd;
        end
      end else if (req_valid && !pend_ff) begin
        pend_ff <= 1'b1;
        pend_cmd_ff <= req_cmd;
      end
    end
  end

  assign busy = pend_ff;
  assign issued = en & mem_rise & pend_ff;
  assign cmd_out = cmd_ff;
  assign cmd_active = act_ff;
endmodule // sdc_cmd_issue

// ===== bench/sdc_top_monitor.sv
// Concurrent checks on the ports of the SDRAM control block.
module sdc_top_monitor #(
  parameter NUM_DEVS = 4,
  parameter ADDR_W = 12
) (
  // Clock, resets and enable.
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic bus_rst,
  input wire logic clk_en,
  // Register port.
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_ready,
  // Block outputs.
  input wire logic [NUM_DEVS-1:0] sdram_cke,
  input wire logic big_endian_mode,
  input wire logic clock_ratio_half,
  input wire logic flash_high_voltage_out,
  input wire logic flash_reset_powerdown_n,
  input wire logic deep_power_down_req,
  input wire logic self_refresh_request,
  input wire logic self_refresh_ack,
  input wire logic init_hold_off
);
  wire tk;
  wire cfg_wr;
  wire dyn_wr;
  assign tk = reg_sel && reg_write && reg_ready && clk_en;
  assign cfg_wr = tk && (reg_addr == 'h0);
  assign dyn_wr = tk && (reg_addr == 'h4);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_CFG_WAIT: assert property ($rose(reg_sel) && reg_addr == 'h0 |-> !reg_ready ##1 reg_ready)
    else $error("config wait state wrong");
  AST_DYN_NOWAIT: assert property (reg_sel && reg_addr == 'h4 |-> reg_ready)
    else $error("dynamic control access waited");
  AST_RATIO: assert property (cfg_wr |=> clock_ratio_half == $past(reg_wdata[8]))
    else $error("clock ratio not written");
  AST_ENDIAN: assert property (cfg_wr |=> big_endian_mode == $past(reg_wdata[0]))
    else $error("endian not written");
  AST_BUS_RST: assert property (bus_rst && !cfg_wr |=> $stable(big_endian_mode))
    else $error("bus reset changed endian");
  AST_HV: assert property (dyn_wr |=> flash_high_voltage_out == $past(reg_wdata[15]))
    else $error("high voltage output wrong");
  AST_RP: assert property (dyn_wr |=> flash_reset_powerdown_n == $past(reg_wdata[14]))
    else $error("flash reset output wrong");
  AST_DP: assert property (dyn_wr |=> deep_power_down_req == $past(reg_wdata[13]))
    else $error("deep power down wrong");
  AST_SR: assert property (dyn_wr |=> self_refresh_request == $past(reg_wdata[2]))
    else $error("self refresh request wrong");
  AST_INIT: assert property (dyn_wr |=> init_hold_off == ($past(reg_wdata[8:7]) != 2'h0))
    else $error("hold off wrong");
  AST_ACK_EXIT: assert property ($fell(self_refresh_ack) |-> !self_refresh_request)
    else $error("ack left without request low");
  AST_ACK_CKE: assert property (self_refresh_ack |=> sdram_cke == '0)
    else $error("clock enable high in self refresh");
  cover property (cfg_wr);
  cover property (dyn_wr && reg_wdata[8:7] == 2'h2);
  cover property ($rose(self_refresh_ack));
endmodule // sdc_top_monitor

// ===== bench/sdc_mem_model.sv
// Behavioural model of the memory side: memory clock, command log and flash supply.
module sdc_mem_model (
  // Clock.
  input wire logic ref_clk,
  // Memory clock made on the memory side.
  output logic memory_core_clock,
  // Command pins and flash controls.
  input wire logic [2:0] sdram_cmd,
  input wire logic sdram_cmd_active,
  input wire logic flash_reset_powerdown_n,
  input wire logic flash_high_voltage_out,
  // Observed results.
  output logic [2:0] last_cmd,
  output logic [31:0] cmd_count,
  output logic [1:0] flash_volts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act_d;
  // The memory clock runs free with an odd phase, so its edges keep a fixed 3ns offset against ref_clk.
  initial begin
    memory_core_clock = 1'b0;
    #3;
    forever #40 memory_core_clock = ~memory_core_clock;
  end
  initial begin
    act_d = 1'b0;
    cmd_count = 32'h0;
    last_cmd = 3'h7;
  end
  always @(posedge ref_clk) begin
    act_d <= sdram_cmd_active;
    if (sdram_cmd_active && !act_d) begin
      cmd_count <= cmd_count + 32'h1;
      last_cmd <= sdram_cmd;
    end
  end
  // Supply level code: 0 is 0V, 1 is 3V, 2 is 8V.
  always_comb begin
    flash_volts = !flash_reset_powerdown_n ? 2'h0 : (flash_high_voltage_out ? 2'h2 : 2'h1);
  end
endmodule // sdc_mem_model

// ===== bench/sdc_top_tb.sv
// Self-checking bench of the SDRAM control block.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module sdc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst, bus_rst, clk_en, reg_sel, reg_write, big_endian_strap, seen;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, q;
  logic [3:0] sdram_idle;
  wire [31:0] reg_rdata, cmd_count;
  wire [3:0] sdram_cke;
  wire [2:0] sdram_cmd, last_cmd;
  wire [1:0] volts;
  wire reg_ready, memory_core_clock, memory_clock_out, sdram_cmd_active, big_endian_mode;
  wire clock_ratio_half, flash_high_voltage_out, flash_reset_powerdown_n, deep_power_down_req;
  wire self_refresh_request, self_refresh_ack, init_hold_off;
  int errors, checks, cyc;
  sdc_top u_dut (.ref_clk, .sys_rst, .bus_rst, .clk_en, .reg_sel, .reg_write, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_ready, .big_endian_strap, .memory_core_clock, .sdram_idle,
    .memory_clock_out, .sdram_cke, .sdram_cmd, .sdram_cmd_active, .big_endian_mode,
    .clock_ratio_half, .flash_high_voltage_out, .flash_reset_powerdown_n, .deep_power_down_req,
    .self_refresh_request, .self_refresh_ack, .init_hold_off);
  sdc_mem_model u_mem (.ref_clk, .memory_core_clock, .sdram_cmd, .sdram_cmd_active,
    .flash_reset_powerdown_n, .flash_high_voltage_out, .last_cmd, .cmd_count, .flash_volts(volts));
  // ****************************************************************
  // Register port and memory clock observation tasks.
  // ****************************************************************
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(negedge ref_clk);
    {reg_sel, reg_write, reg_addr, reg_wdata} = {1'b1, w, a, d};
    n = 0;
    #1;
    while (reg_ready !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(reg_ready, 1'b1)
    q = reg_rdata;
    @(negedge ref_clk);
    reg_sel = 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic poll_ack(input logic v);
    int n;
    n = 0;
    do begin
      bus(12'h008, 1'b0, 32'h0);
      n++;
    end while (q[2] !== v && n < 40);
    `CHK(q[2], v)
  endtask
  task automatic watch_clk;
    seen = 1'b0;
    repeat (24) @(negedge ref_clk) seen = seen | memory_clock_out;
  endtask
  task automatic count_rises(output int r);
    logic p;
    r = 0;
    p = memory_clock_out;
    repeat (64) begin
      @(negedge ref_clk);
      r += (memory_clock_out && !p);
      p = memory_clock_out;
    end
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset;
    `CHK({self_refresh_request, self_refresh_ack}, 2'h3)
    `CHK({flash_high_voltage_out, flash_reset_powerdown_n, deep_power_down_req}, 3'h0)
    `CHK(init_hold_off, 1'b0)
    bus(12'h004, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0006)
    bus(12'h000, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0001)
  endtask
  task automatic t_cfg;
    bus(12'h000, 1'b1, 32'h0000_0100);
    settle;
    `CHK({clock_ratio_half, big_endian_mode}, 2'h2)
    bus_rst = 1'b1;
    settle;
    bus_rst = 1'b0;
    bus(12'h000, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0100)
    bus(12'h000, 1'b1, 32'h0000_0001);
    bus(12'h000, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0001)
    bus(12'h00c, 1'b1, 32'hffff_ffff);
    bus(12'h00c, 1'b0, 32'h0);
    `CHK(q, 32'h0)
  endtask
  task automatic t_sref_exit;
    bus(12'h004, 1'b1, 32'h0000_0001);
    poll_ack(1'b0);
    settle;
    `CHK(sdram_cke, 4'hf)
    sdram_idle = 4'h5;
    bus(12'h004, 1'b1, 32'h0);
    settle;
    `CHK(sdram_cke, 4'ha)
    sdram_idle = 4'hf;
  endtask
  task automatic t_init;
    logic [31:0] n0;
    int n;
    for (int i = 1; i < 4; i++) begin
      n = 0;
      while (sdram_cmd_active !== 1'b0 && n < 20) begin
        @(negedge ref_clk);
        n++;
      end
      n0 = cmd_count;
      bus(12'h004, 1'b1, {23'h0, i[1:0], 7'h01});
      settle;
      `CHK(init_hold_off, 1'b1)
      n = 0;
      while (cmd_count === n0 && n < 60) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK(last_cmd, (i == 1) ? 3'h0 : (i == 2) ? 3'h2 : 3'h7)
      bus(12'h004, 1'b1, 32'h0000_0001);
      settle;
      `CHK(init_hold_off, 1'b0)
    end
  endtask
  task automatic t_flash;
    for (int i = 0; i < 4; i++) begin
      bus(12'h004, 1'b1, {16'h0, i[1:0], 14'h0001});
      settle;
      `CHK({flash_high_voltage_out, flash_reset_powerdown_n}, i[1:0])
      `CHK(volts, i[0] ? (i[1] ? 2'h2 : 2'h1) : 2'h0)
    end
    bus(12'h004, 1'b1, 32'h0000_2001);
    settle;
    `CHK({deep_power_down_req, sdram_cke}, 5'h10)
    clk_en = 1'b0;
    bus(12'h004, 1'b1, 32'h0000_8001);
    `CHK(flash_high_voltage_out, 1'b0)
    clk_en = 1'b1;
  endtask
  task automatic t_clk;
    int r;
    bus(12'h004, 1'b1, 32'h0000_0023);
    settle;
    watch_clk;
    `CHK(seen, 1'b0)
    bus(12'h004, 1'b1, 32'h0000_0003);
    watch_clk;
    `CHK(seen, 1'b1)
    count_rises(r);
    `CHK(r > 6 && r < 10, 1'b1)
    bus(12'h000, 1'b1, 32'h0000_0101);
    count_rises(r);
    `CHK(r > 2 && r < 6, 1'b1)
    bus(12'h000, 1'b1, 32'h0000_0001);
    bus(12'h004, 1'b1, 32'h0000_0001);
    settle;
    watch_clk;
    `CHK(seen, 1'b0)
  endtask
  task automatic t_sref_enter;
    bus(12'h004, 1'b1, 32'h0000_0005);
    poll_ack(1'b1);
    settle;
    `CHK(last_cmd, 3'h1)
    `CHK(sdram_cke, 4'h0)
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************************************
  // Clock, timeout and main sequence.
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    {sys_rst, bus_rst, clk_en, reg_sel, reg_write, big_endian_strap} = 6'b101001;
    {reg_addr, reg_wdata, sdram_idle} = {12'h0, 32'h0, 4'hf};
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset;
    t_cfg;
    t_sref_exit;
    t_init;
    t_flash;
    t_clk;
    t_sref_enter;
    print_verdict;
  end
endmodule // sdc_top_tb
bind sdc_top sdc_top_monitor #(.NUM_DEVS(NUM_DEVS), .ADDR_W(ADDR_W)) u_mon (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .bus_rst(bus_rst), .clk_en(clk_en), .reg_sel(reg_sel),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(reg_ready),
  .sdram_cke(sdram_cke), .big_endian_mode(big_endian_mode), .clock_ratio_half(clock_ratio_half),
  .flash_high_voltage_out(flash_high_voltage_out), .init_hold_off(init_hold_off),
  .flash_reset_powerdown_n(flash_reset_powerdown_n), .deep_power_down_req(deep_power_down_req),
  .self_refresh_request(self_refresh_request), .self_refresh_ack(self_refresh_ack));
